/* core/ofl_loader.sv */
// Fuse loader: copies oscillator and system fuse bytes into their targets after reset.
// Assumes an Avalon-MM master with waitrequest and a fuse array that raises fuse_ready.
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
module ofl_loader #(
  parameter logic [ofl_pkg::COARSE_W-1:0] COARSE_16M = 7'h20,
  parameter logic [ofl_pkg::COARSE_W-1:0] COARSE_20M = 7'h28,
  parameter logic [ofl_pkg::TEMP_W-1:0] TEMP_16M = 4'h8,
  parameter logic [ofl_pkg::TEMP_W-1:0] TEMP_20M = 4'h8
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic fuse_ready,
  input wire logic [7:0] oscillator_config_fuse,
  input wire logic [7:0] system_config0_fuse,
  input wire logic chip_erase,
  input wire logic device_locked,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic load_done,
  output logic [1:0] osc_frequency_select,
  output logic osc_run_20m,
  output ofl_pkg::ofl_cal_t osc_cal,
  output ofl_pkg::ofl_crc_t crc_scan,
  output logic reset_pin_is_reset,
  output logic eeprom_keep_on_erase,
  output logic eeprom_erase
);
  ofl_pkg::ofl_state_t state_reg;
  ofl_pkg::ofl_state_t state_next;
  logic [7:0] osc_fuse_reg;
  logic [7:0] sys_fuse_reg;
  ofl_pkg::ofl_cal_t cal_reg;
  ofl_pkg::ofl_cal_t cal_next;
  ofl_pkg::ofl_crc_t crc_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic erase_reg;
  logic run20_reg;
  logic [ofl_pkg::COARSE_W-1:0] fac_coarse;
  logic [ofl_pkg::TEMP_W-1:0] fac_temp;

  function automatic ofl_pkg::ofl_crc_t crc_decode(input logic [1:0] code);
    ofl_pkg::ofl_crc_t c;
    c.enable = (code != ofl_pkg::CRC_NONE); // R9
    c.boot = c.enable;
    c.app_code = (code == ofl_pkg::CRC_FLASH) || (code == ofl_pkg::CRC_BOOTAPP); // R6 R9
    c.app_data = (code == ofl_pkg::CRC_FLASH); // R6
    return c;
  endfunction

  function automatic logic index_hit(input logic [7:0] addr, input logic [7:0] idx);
    return (addr[1:0] == 2'h0) && (addr[7:2] == idx[5:0]);
  endfunction

  ofl_cal_select #(
    .COARSE_16M(COARSE_16M),
    .COARSE_20M(COARSE_20M),
    .TEMP_16M(TEMP_16M),
    .TEMP_20M(TEMP_20M)
  ) u_cal_select (
    .freq_sel(oscillator_config_fuse[ofl_pkg::FREQ_SEL_LSB +: 2]),
    .coarse(fac_coarse),
    .temp(fac_temp)
  );

  // Loading happens once per reset; later fuse changes wait for the next reset
  wire loading = (state_reg == ofl_pkg::ST_LOAD) && fuse_ready; // R12
  assign state_next = (state_reg == ofl_pkg::ST_RUN || fuse_ready) ? ofl_pkg::ST_RUN : ofl_pkg::ST_LOAD;

  // Bus decode; the bus is stalled until the load has finished
  wire running = (state_reg == ofl_pkg::ST_RUN);
  wire req = avs_read || avs_write;
  wire accept = running && req && wait_reg;
  wire commit = req && !wait_reg;
  wire hit_osc = index_hit(avs_address, ofl_pkg::OSC_CFG_IDX);
  wire hit_sys = index_hit(avs_address, ofl_pkg::SYS_CFG0_IDX);
  wire hit_cal_a = index_hit(avs_address, ofl_pkg::CAL_A_IDX);
  wire hit_cal_b = index_hit(avs_address, ofl_pkg::CAL_B_IDX);
  wire cal_wr_ok = commit && avs_write && avs_byteenable[0] && !cal_reg.lock; // R2
  wire [31:0] cal_a_word = {{(32 - ofl_pkg::COARSE_W){1'b0}}, cal_reg.coarse};
  wire [31:0] cal_b_word = {24'h0, cal_reg.lock, {(7 - ofl_pkg::TEMP_W){1'b0}}, cal_reg.temp};

  // Fuse images are read-only: writes to them are dropped
  assign rdata_next = hit_osc ? {24'h0, osc_fuse_reg} :
                      hit_sys ? {24'h0, sys_fuse_reg} : // R8
                      hit_cal_a ? cal_a_word :
                      hit_cal_b ? cal_b_word : 32'h0;

  always_comb begin
    cal_next = cal_reg;
    if (loading) begin
      cal_next.lock = oscillator_config_fuse[ofl_pkg::OSC_LOCK_BIT]; // R1
      cal_next.coarse = fac_coarse; // R4
      cal_next.temp = fac_temp; // R4
    end else if (cal_wr_ok && hit_cal_a) begin
      cal_next.coarse = avs_writedata[ofl_pkg::COARSE_W-1:0]; // R2
    end else if (cal_wr_ok && hit_cal_b) begin
      cal_next.temp = avs_writedata[ofl_pkg::TEMP_W-1:0]; // R2
    end
  end

  // Once loaded, locked parts lose EEPROM on chip erase even with the keep bit set
  wire erase_ee = chip_erase && running && (!sys_fuse_reg[ofl_pkg::EE_KEEP_BIT] || device_locked); // R11

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ofl_pkg::ST_LOAD;
      osc_fuse_reg <= ofl_pkg::OSC_CFG_DEFAULT; // R7
      sys_fuse_reg <= ofl_pkg::SYS_CFG0_DEFAULT; // R7
      run20_reg <= 1'b1;
    end else if (clk_en) begin
      state_reg <= state_next;
      if (loading) begin
        osc_fuse_reg <= oscillator_config_fuse; // R12
        // Registered so the rate pin never glitches while the image settles
        run20_reg <= (oscillator_config_fuse[ofl_pkg::FREQ_SEL_LSB +: 2] != ofl_pkg::FREQ_16M); // R3
        sys_fuse_reg <= system_config0_fuse; // R5
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cal_reg <= '0;
      crc_reg <= '0;
    end else if (clk_en) begin
      cal_reg <= cal_next;
      if (loading) begin
        crc_reg <= crc_decode(system_config0_fuse[ofl_pkg::CRC_REGION_LSB +: 2]); // R5
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0;
      erase_reg <= 1'b0;
      load_done <= 1'b0;
    end else if (clk_en) begin
      if (accept) begin
        wait_reg <= 1'b0;
        rdata_reg <= avs_read ? rdata_next : 32'h0;
      end else begin
        wait_reg <= 1'b1;
      end
      erase_reg <= erase_ee;
      load_done <= running;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  assign eeprom_erase = erase_reg;
  assign osc_cal = cal_reg;
  assign crc_scan = crc_reg;
  assign osc_frequency_select = osc_fuse_reg[ofl_pkg::FREQ_SEL_LSB +: 2]; // R3
  assign osc_run_20m = run20_reg; // R3
  assign reset_pin_is_reset = sys_fuse_reg[ofl_pkg::RST_PIN_BIT]; // R10
  assign eeprom_keep_on_erase = sys_fuse_reg[ofl_pkg::EE_KEEP_BIT]; // R8
endmodule

/* core/ofl_pkg.sv */
// Constants and types for the oscillator and system fuse loader.
// Assumes fuse bytes are presented by the nonvolatile array once it is ready after reset.
// Functional notes
// R1: At load, oscillator fuse bit 7 is copied into calibration B lock bit.
// R2: Lock 0 lets software change calibration registers; lock 1 ignores such writes.
// R3: Frequency select bits 1:0: 1 is 16 MHz, 2 is 20 MHz, 0 and 3 reserved.
// R4: Frequency select picks the factory coarse and temperature calibration set.
// R5: At load, system fuse bits 7:6 are handed to the flash CRC scanner.
// R6: Region code 0 scans boot, application code and application data.
// R7: Factory programmed bytes are 0x02 and 0xE4; reset does not force them. The code resets the fuse images to these values until the load.
// R8: Reset pin function sits at bit 3, EEPROM keep at bit 0, read-only.
// R9: Region code 1 scans boot, 2 boot plus code, 3 disables the scan.
// R10: Reset pin function 0 makes the pin GPIO, 1 makes it external reset.
// R11: Chip erase clears EEPROM unless keep bit set and device unlocked.
// R12: Fuses are copied once at end of start-up; changes need another reset.
package ofl_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] OSC_CFG_IDX = 8'h02;
  localparam logic [7:0] SYS_CFG0_IDX = 8'h05;
  localparam logic [7:0] CAL_A_IDX = 8'h10;
  localparam logic [7:0] CAL_B_IDX = 8'h11;
  localparam logic [7:0] OSC_CFG_DEFAULT = 8'h02;
  localparam logic [7:0] SYS_CFG0_DEFAULT = 8'he4;
  localparam int OSC_LOCK_BIT = 7;
  localparam int FREQ_SEL_LSB = 0;
  localparam int CRC_REGION_LSB = 6;
  localparam int RST_PIN_BIT = 3;
  localparam int EE_KEEP_BIT = 0;
  localparam int CAL_B_LOCK_BIT = 7;
  localparam int COARSE_W = 7;
  localparam int TEMP_W = 4;
  localparam logic [1:0] FREQ_16M = 2'h1;
  localparam logic [1:0] FREQ_20M = 2'h2;
  localparam logic [1:0] CRC_FLASH = 2'h0;
  localparam logic [1:0] CRC_BOOT = 2'h1;
  localparam logic [1:0] CRC_BOOTAPP = 2'h2;
  localparam logic [1:0] CRC_NONE = 2'h3;

  typedef enum logic [0:0] {ST_LOAD, ST_RUN} ofl_state_t;

  typedef struct packed {
    logic enable;
    logic boot;
    logic app_code;
    logic app_data;
  } ofl_crc_t;

  typedef struct packed {
    logic lock;
    logic [COARSE_W-1:0] coarse;
    logic [TEMP_W-1:0] temp;
  } ofl_cal_t;
endpackage

/* core/ofl_cal_select.sv */
// Factory calibration set selection by frequency select code.
// Assumes the factory sets are constants fixed at elaboration.
`timescale 1ns/1ps
module ofl_cal_select #(
  parameter logic [ofl_pkg::COARSE_W-1:0] COARSE_16M = 7'h20,
  parameter logic [ofl_pkg::COARSE_W-1:0] COARSE_20M = 7'h28,
  parameter logic [ofl_pkg::TEMP_W-1:0] TEMP_16M = 4'h8,
  parameter logic [ofl_pkg::TEMP_W-1:0] TEMP_20M = 4'h8
) (
  input wire logic [1:0] freq_sel,
  output logic [ofl_pkg::COARSE_W-1:0] coarse,
  output logic [ofl_pkg::TEMP_W-1:0] temp
);
  // Reserved codes fall back to the 20 MHz set so the oscillator stays in a known band
  wire is_16m = (freq_sel == ofl_pkg::FREQ_16M); // R3
  assign coarse = is_16m ? COARSE_16M : COARSE_20M; // R4
  assign temp = is_16m ? TEMP_16M : TEMP_20M; // R4
endmodule

/* dv/ofl_loader_checker.sv */
// Port checker for the fuse loader, bound at the foot.
// Assumes one clock; fuses stay steady around the load.
`timescale 1ns/1ps
module ofl_loader_checker (
  input wire logic clk_sys, rst_b, clk_en, chip_erase, device_locked, avs_write, avs_waitrequest,
  input wire logic load_done, eeprom_keep_on_erase, eeprom_erase,
  input wire logic [7:0] oscillator_config_fuse, system_config0_fuse, avs_address,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [1:0] osc_frequency_select,
  input wire ofl_pkg::ofl_cal_t osc_cal,
  input wire ofl_pkg::ofl_crc_t crc_scan
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire erase_due = chip_erase && (!eeprom_keep_on_erase || device_locked);
  // Region code picks one nibble of the coverage table
  wire [3:0] crc_want = 4'(16'h0ecf >> {system_config0_fuse[7:6], 2'h0});
  sequence loaded; $rose(load_done); endsequence
  sequence cal_wr;
    avs_write && !avs_waitrequest && clk_en && avs_address == 8'h40 && avs_byteenable[0];
  endsequence
  chk_lock_copy: assert property (loaded |-> osc_cal.lock == $past(oscillator_config_fuse[7]))
    else $error("lock bit");
  chk_freq_copy: assert property (loaded |-> osc_frequency_select == $past(oscillator_config_fuse[1:0]))
    else $error("freq select");
  chk_crc_region: assert property (loaded |-> crc_scan == $past(crc_want)) else $error("crc region");
  chk_erase_pulse: assert property (load_done && clk_en |=> eeprom_erase == $past(erase_due))
    else $error("erase");
  chk_fuse_hold: assert property (load_done |=> $stable(osc_frequency_select) && $stable(crc_scan))
    else $error("hold");
  chk_bus_stall: assert property (!load_done |-> avs_waitrequest) else $error("early bus");
  chk_cal_write: assert property (cal_wr ##0 !osc_cal.lock |=> osc_cal.coarse == $past(avs_writedata[6:0]))
    else $error("cal write");
  chk_cal_locked: assert property (cal_wr ##0 osc_cal.lock |=> $stable(osc_cal)) else $error("cal lock");
endmodule
bind ofl_loader ofl_loader_checker u_chk (.*);

/* dv/ofl_loader_test.sv */
// Bench for the fuse loader: factory fuses, then each code.
// Assumes the bound checker; drives every port itself.
`timescale 1ns/1ps
module ofl_loader_test;
  logic clk_sys = 1'b0, rst_b = 1'b0, clk_en = 1'b1, fuse_ready = 1'b0, chip_erase = 1'b0, device_locked = 1'b0;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, load_done, osc_run_20m, reset_pin_is_reset;
  logic eeprom_keep_on_erase, eeprom_erase;
  logic [7:0] oscillator_config_fuse = 8'h02, system_config0_fuse = 8'he4, avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [3:0] avs_byteenable = 4'hf;
  logic [1:0] osc_frequency_select;
  ofl_pkg::ofl_cal_t osc_cal;
  ofl_pkg::ofl_crc_t crc_scan;
  int n_errors = 0, n_checks = 0;
  // Distinct factory sets so a wrong pick shows
  ofl_loader #(.COARSE_16M(7'h11), .COARSE_20M(7'h33), .TEMP_16M(4'h5), .TEMP_20M(4'ha)) dut (.*);
  initial forever #5 clk_sys = ~clk_sys;
  task automatic end_sim;
    if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      n_errors++;
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    {avs_address, avs_writedata, avs_read, avs_write} <= {a, d, !wr, wr};
    for (i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    {avs_read, avs_write} <= 2'h0;
    if (i == 40) begin
      n_errors++;
      end_sim();
    end
    // Idle edge so a following request never lands in the release step
    @(posedge clk_sys);
  endtask
  task automatic boot(input logic [7:0] o, input logic [7:0] s);
    {rst_b, oscillator_config_fuse, system_config0_fuse} <= {1'b0, o, s};
    repeat (2) @(posedge clk_sys);
    {rst_b, fuse_ready} <= 2'h3;
    repeat (3) @(posedge clk_sys);
    chk("load", 1, load_done);
  endtask
  task automatic t_factory;
    boot(8'h02, 8'he4);
    bus(1, 8'h14, 32'h1b);
    bus(0, 8'h14, 0);
    chk("sys fuse", 32'he4, rd);
    bus(0, 8'h80, 0);
    chk("unmapped", 0, rd);
    // A low enable must swallow an erase request entirely
    clk_en <= 1'b0;
    chip_erase <= 1'b1;
    @(posedge clk_sys);
    clk_en <= 1'b1;
    chip_erase <= 1'b0;
    @(posedge clk_sys);
    chk("frozen erase", 0, eeprom_erase);
  endtask
  task automatic t_codes;
    logic [1:0] c;
    logic [7:0] o;
    logic [6:0] co;
    for (int k = 0; k < 4; k++) begin
      c = 2'(k);
      o = {c[0], 5'h00, c};
      co = c == 2'h1 ? 7'h11 : 7'h33;
      device_locked <= c[1];
      boot(o, {c, 2'h0, c[1], 2'h0, c[0]});
      chk("freq", c, osc_frequency_select);
      chk("rate", c != 2'h1, osc_run_20m);
      chk("temp", c == 2'h1 ? 4'h5 : 4'ha, osc_cal.temp);
      chk("crc", 4'(16'h0ecf >> {c, 2'h0}), crc_scan);
      chk("pin", c[1], reset_pin_is_reset);
      chk("keep", c[0], eeprom_keep_on_erase);
      chk("lock", c[0], osc_cal.lock);
      bus(0, 8'h44, 0);
      chk("cal b", {c[0], 3'h0, (c == 2'h1 ? 4'h5 : 4'ha)}, rd);
      bus(0, 8'h08, 0);
      chk("osc fuse", o, rd);
      bus(1, 8'h40, 32'h55);
      bus(0, 8'h40, 0);
      chk("cal", c[0] ? co : 7'h55, rd);
      chip_erase <= 1'b1;
      @(posedge clk_sys);
      chip_erase <= 1'b0;
      @(posedge clk_sys);
      chk("erase", !c[0] || c[1], eeprom_erase);
      oscillator_config_fuse <= ~o;
      @(posedge clk_sys);
    end
  endtask
  initial begin
    t_factory();
    t_codes();
    end_sim();
  end
endmodule
